// *** rtl/dsip_consts.vh ***
// constants for the serial input port of the converter control block
// assumes inclusion by bare name from the design files under rtl/
//
// Summary of operation
// - falling serial clock edges shift the data line into a sixteen-bit register
// - frame select is active low; shifting is enabled only while it is low
// - after the sixteenth falling edge the word enters a two-entry buffer, dropped if full, and loads the converter register while conv_ready_i is high
// - frame select rising after one to fifteen edges aborts, with no edges is silent; converter register unchanged
// - reset forces the zero code until a complete valid write arrives
// - three power-down functions are selected through the same serial word
// - converter register holds a twelve-bit code taken from the sixteen-bit word
`ifndef DSIP_CONSTS_VH
`define DSIP_CONSTS_VH

`define DSIP_WORD_BITS 16
`define DSIP_CODE_BITS 12
`define DSIP_CNT_BITS 5
`define DSIP_MODE_LSB 12
`define DSIP_MODE_MSB 13
`define DSIP_CODE_RESET 12'h000
`define DSIP_MODE_NORMAL 2'h0
`define DSIP_MODE_PD1 2'h1
`define DSIP_MODE_PD2 2'h2
`define DSIP_MODE_PD3 2'h3
`define DSIP_WORD_LAST 5'h10
`define DSIP_SYNC_STAGES 3
`define DSIP_PIN_IDLE 3'h6

`endif

// *** rtl/dsip_buf2.v ***
// two-entry buffer with valid and ready on both sides
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/100ps
`default_nettype none
module dsip_buf2 #(
    parameter WIDTH = 16
) (
    // clock and reset
    input wire sys_clk_i,
    input wire rst_n_i,
    // filling side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // draining side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem_r [0:1];
    reg wr_ptr_r;
    reg rd_ptr_r;
    reg [1:0] count_r;
    wire push;
    wire pop;

    // handshake terms
    assign in_ready_o = (count_r != 2'h2);
    assign out_valid_o = (count_r != 2'h0);
    assign out_data_o = mem_r[rd_ptr_r];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // pointers and occupancy
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r <= 2'h0;
        end else begin
            if (push)
                wr_ptr_r <= ~wr_ptr_r;
            if (pop)
                rd_ptr_r <= ~rd_ptr_r;
            if (push & ~pop)
                count_r <= count_r + 2'h1;
            else if (pop & ~push)
                count_r <= count_r - 2'h1;
        end
    end

    // storage
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_r[0] <= {WIDTH{1'b0}};
            mem_r[1] <= {WIDTH{1'b0}};
        end else if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end
endmodule // dsip_buf2
`default_nettype wire

// *** rtl/dsip_serial_port.v ***
// serial input port: frame select, serial clock and data line into a 12-bit converter register
// assumes the link pins are asynchronous to sys_clk_i, serial clock well below a quarter of it
// the converter may stall for two words; a third completed word is dropped
`timescale 1ns/100ps
`default_nettype none
`include "dsip_consts.vh"
module dsip_serial_port #(
    parameter WORD_BITS = `DSIP_WORD_BITS,
    parameter CODE_BITS = `DSIP_CODE_BITS
) (
    // clock and reset
    input wire sys_clk_i,
    input wire rst_n_i,
    // serial link pins
    input wire sync_n_i,
    input wire sclk_i,
    input wire din_i,
    // converter side
    output reg [CODE_BITS-1:0] analog_output_o,
    output reg [1:0] pd_mode_o,
    output reg code_valid_o,
    output wire update_pulse_o,
    output wire abort_pulse_o,
    output wire word_ready_o,
    input wire conv_ready_i
);
    // pin positions inside the sampler vectors
    localparam PIN_DIN = 0;
    localparam PIN_SCLK = 1;
    localparam PIN_SYNC = 2;
    localparam PIN_COUNT = 3;
    // idle pin levels: frame closed, serial clock high, data low
    // stage count and idle levels come from the constants header
    localparam [PIN_COUNT-1:0] PIN_IDLE = `DSIP_PIN_IDLE;
    localparam SYNC_LAST = `DSIP_SYNC_STAGES - 1;

    // frame engine states
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_SHIFT = 2'h1;
    localparam [1:0] ST_HOLD = 2'h2;

    // raw pins, their filtered levels and last cycle's levels
    wire [PIN_COUNT-1:0] pins_raw;
    wire [PIN_COUNT-1:0] pins_flt;
    wire [PIN_COUNT-1:0] pins_prev;
    wire sync_lvl;
    wire sclk_lvl;
    wire din_lvl;
    wire sclk_fall;
    wire sync_rise;
    wire sync_fall;

    // frame engine state and next values
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [WORD_BITS-1:0] shift_r;
    reg [WORD_BITS-1:0] shift_nxt;
    reg [`DSIP_CNT_BITS-1:0] cnt_r;
    reg [`DSIP_CNT_BITS-1:0] cnt_nxt;
    reg done_r;
    reg done_nxt;
    reg abort_r;
    reg abort_nxt;

    // converter side
    reg upd_r;
    wire word_push;
    wire buf_in_ready;
    wire buf_valid;
    wire [WORD_BITS-1:0] buf_data;
    wire buf_take;
    genvar g;

    // pins gathered in a fixed order
    assign pins_raw[PIN_DIN] = din_i;
    assign pins_raw[PIN_SCLK] = sclk_i;
    assign pins_raw[PIN_SYNC] = sync_n_i;

    // one three-stage sampler per pin; the first stage feeds only the second
    // the serial clock is treated as data, so its half periods must span
    // several system clocks or neighbouring edges merge in the filter
    generate
        for (g = 0; g < PIN_COUNT; g = g + 1) begin : g_pin
            reg [`DSIP_SYNC_STAGES-1:0] sh_r;
            reg lvl_r;
            reg prev_r;
            // sampler chain, reset to the pin's idle level
            always @(posedge sys_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    sh_r <= {`DSIP_SYNC_STAGES{PIN_IDLE[g]}};
                end else begin
                    sh_r <= {sh_r[SYNC_LAST-1:0], pins_raw[g]};
                end
            end
            // level moves only once stages two and three agree
            always @(posedge sys_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    lvl_r <= PIN_IDLE[g];
                    prev_r <= PIN_IDLE[g];
                end else begin
                    if (sh_r[SYNC_LAST-1] == sh_r[SYNC_LAST])
                        lvl_r <= sh_r[SYNC_LAST];
                    prev_r <= lvl_r;
                end
            end
            assign pins_flt[g] = lvl_r;
            assign pins_prev[g] = prev_r;
        end
    endgenerate

    // filtered levels and the edges the frame engine acts on
    // idle levels at reset keep a false edge from following reset
    assign din_lvl = pins_flt[PIN_DIN];
    assign sclk_lvl = pins_flt[PIN_SCLK];
    assign sync_lvl = pins_flt[PIN_SYNC];
    assign sclk_fall = pins_prev[PIN_SCLK] & ~sclk_lvl;
    assign sync_rise = ~pins_prev[PIN_SYNC] & sync_lvl;
    assign sync_fall = pins_prev[PIN_SYNC] & ~sync_lvl;

    // frame engine: a frame opens on a falling select, shifts sixteen bits,
    // then holds until select rises; a rise after one to fifteen bits is an
    // abort, a rise with no bits at all is silent
    always @* begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        shift_nxt = shift_r;
        done_nxt = 1'b0;
        abort_nxt = 1'b0;
        case (state_r)
            ST_IDLE: begin
                // frame closed: counter parked at zero
                cnt_nxt = {`DSIP_CNT_BITS{1'b0}};
                if (sync_fall)
                    state_nxt = ST_SHIFT;
            end
            ST_SHIFT: begin
                if (sync_rise) begin
                    // early rise throws the partial word away
                    state_nxt = ST_IDLE;
                    if (cnt_r != {`DSIP_CNT_BITS{1'b0}})
                        abort_nxt = 1'b1;
                end else if (sclk_fall) begin
                    // data taken on filtered falling clock edges only
                    shift_nxt = {shift_r[WORD_BITS-2:0], din_lvl};
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == `DSIP_WORD_LAST - 5'h01) begin
                        done_nxt = 1'b1;
                        state_nxt = ST_HOLD;
                    end
                end
            end
            ST_HOLD: begin
                // word complete: later clock edges are ignored
                if (sync_lvl)
                    state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // frame engine registers; done and abort are one-cycle strobes
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= ST_IDLE;
            shift_r <= {WORD_BITS{1'b0}};
            cnt_r <= {`DSIP_CNT_BITS{1'b0}};
            done_r <= 1'b0;
            abort_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
            abort_r <= abort_nxt;
        end
    end

    // the link has no back-pressure, so a full buffer cannot stall the host
    // completed word enters the buffer; stall drops it only when full
    assign word_push = done_r;
    assign word_ready_o = buf_in_ready;

    dsip_buf2 #(
        .WIDTH(WORD_BITS)
    ) u_buf (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(word_push),
        .in_ready_o(buf_in_ready),
        .in_data_i(shift_r),
        .out_valid_o(buf_valid),
        .out_ready_i(conv_ready_i),
        .out_data_o(buf_data)
    );

    assign buf_take = buf_valid & conv_ready_i;

    // converter register: zero code until first full word
    // the update pulse marks the first cycle in which the new code shows
    // a word is applied only while conv_ready_i is high
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            analog_output_o <= `DSIP_CODE_RESET;
            pd_mode_o <= `DSIP_MODE_NORMAL;
            code_valid_o <= 1'b0;
            upd_r <= 1'b0;
        end else begin
            upd_r <= buf_take;
            if (buf_take) begin
                analog_output_o <= buf_data[CODE_BITS-1:0];
                pd_mode_o <= buf_data[`DSIP_MODE_MSB:`DSIP_MODE_LSB];
                code_valid_o <= 1'b1;
            end
        end
    end

    assign update_pulse_o = upd_r;
    assign abort_pulse_o = abort_r;
endmodule // dsip_serial_port
`default_nettype wire

// *** verification/dsip_host.sv ***
// host model driving the three-wire link
// assumes a 10 MHz clock; serial clock half period of 400 ns
`timescale 1ns/100ps
`default_nettype none
module dsip_host (
    // clock
    input wire logic clk_i,
    // link pins
    output logic sync_n_o,
    output logic sclk_o,
    output logic din_o
);
    // idle link: frame closed, serial clock high
    initial begin
        sync_n_o = 1'b1;
        sclk_o = 1'b1;
        din_o = 1'b0;
    end
    // one frame of n bits, msb first
    task automatic xfer(input logic [15:0] w, input int n);
        sync_n_o = 1'b0;
        repeat (4) @(negedge clk_i);
        for (int i = 15; i > 15 - n; i--) begin
            din_o = w[i];
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b0;
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b1;
        end
        sync_n_o = 1'b1;
        din_o = ~din_o; // released line shows no stale bit
        repeat (12) @(negedge clk_i);
    endtask
endmodule // dsip_host

// *** verification/dsip_sp_assertions.sv ***
// port assertions for the serial input port
// assumes bind onto dsip_serial_port, one clock
`timescale 1ns/100ps
`default_nettype none
module dsip_sp_assertions #(
    parameter WORD_BITS = 16,
    parameter CODE_BITS = 12
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic sync_n_i,
    input wire logic conv_ready_i,
    input wire logic [CODE_BITS-1:0] analog_output_o,
    input wire logic [1:0] pd_mode_o,
    input wire logic code_valid_o,
    input wire logic update_pulse_o,
    input wire logic abort_pulse_o,
    input wire logic word_ready_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // output relations
    a_zero_hold: assert property (!code_valid_o |-> analog_output_o == 0) else $error("code early");
    a_valid_stays: assert property (code_valid_o |=> code_valid_o) else $error("valid lost");
    a_abort_single: assert property (abort_pulse_o |=> !abort_pulse_o) else $error("long abort");
    a_code_pulse: assert property ($changed(analog_output_o) |-> update_pulse_o) else $error("no pulse");
    a_mode_pulse: assert property ($changed(pd_mode_o) |-> update_pulse_o) else $error("mode pulse");
    a_load_ready: assert property ($changed(analog_output_o) |-> $past(conv_ready_i)) else $error("load");
    a_abort_keeps: assert property (abort_pulse_o |-> $stable(analog_output_o)) else $error("abort load");
    a_idle_quiet: assert property (sync_n_i [*8] |=> !abort_pulse_o) else $error("idle abort");
    // main scenarios
    c_upd: cover property (update_pulse_o);
    c_abort: cover property (abort_pulse_o);
    c_full: cover property (!word_ready_o);
endmodule // dsip_sp_assertions
`default_nettype wire

// *** verification/dsip_serial_port_tb.sv ***
// self-checking bench for the serial input port
// assumes the host model drives the link pins
`timescale 1ns/100ps
`default_nettype none
module dsip_serial_port_tb;
    logic sys_clk_i, rst_n_i, conv_ready_i, sync_n, sclk, din, valid, upd, abrt, wrdy;
    logic [11:0] code;
    logic [1:0] mode;
    logic [15:0] words [4] = '{16'hc5a3, 16'h1abc, 16'h2fff, 16'h3001};
    int fails = 0, checked = 0, n_upd = 0, n_abrt = 0;
    dsip_serial_port dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sync_n_i(sync_n), .sclk_i(sclk),
        .din_i(din), .analog_output_o(code), .pd_mode_o(mode), .code_valid_o(valid), .update_pulse_o(upd),
        .abort_pulse_o(abrt), .word_ready_o(wrdy), .conv_ready_i(conv_ready_i));
    dsip_host host_u (.clk_i(sys_clk_i), .sync_n_o(sync_n), .sclk_o(sclk), .din_o(din));
    // clock
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    // pulse counters
    always @(posedge sys_clk_i) begin
        if (upd === 1'b1) n_upd <= n_upd + 1;
        if (abrt === 1'b1) n_abrt <= n_abrt + 1;
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_sim;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // bounded wait for a number of updates
    task wait_upd(input int n);
        for (int k = 0; k < 300 && n_upd < n; k++) @(negedge sys_clk_i);
        if (n_upd < n) begin
            fails++;
            end_sim;
        end
    endtask
    // reset state, aborted and empty frames
    task t_abort;
        chk(code, 16'h0);
        chk(valid, 16'h0);
        host_u.xfer(16'h0abc, 9);
        host_u.xfer(16'h0abc, 0);
        chk(16'(n_abrt), 16'h1);
        chk(16'(n_upd), 16'h0);
        chk(code, 16'h0);
        $display("abort test done");
    endtask
    // full write, every mode
    task t_write(input logic [15:0] w);
        int t;
        t = n_upd + 1;
        host_u.xfer(w, 16);
        wait_upd(t);
        chk(code, w[11:0]);
        chk(mode, w[13:12]);
        chk(valid, 16'h1);
        chk(16'(n_upd), 16'(t));
        $display("write test done");
    endtask
    // reset in mid-run drops back to the zero code
    task t_reset;
        rst_n_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        chk(code, 16'h0);
        chk(mode, 16'h0);
        chk(valid, 16'h0);
        chk(wrdy, 16'h1);
        $display("reset test done");
    endtask
    // stalled converter, buffer full, then drained
    task t_stall;
        int t;
        t = n_upd;
        conv_ready_i = 1'b0;
        host_u.xfer(16'h0111, 16);
        host_u.xfer(16'h0222, 16);
        chk(wrdy, 16'h0);
        chk(code, 16'h001);
        host_u.xfer(16'h0333, 16);
        conv_ready_i = 1'b1;
        wait_upd(t + 2);
        repeat (10) @(negedge sys_clk_i);
        chk(code, 16'h222);
        chk(16'(n_upd), 16'(t + 2));
        $display("stall test done");
    endtask
    initial begin
        rst_n_i = 1'b0;
        conv_ready_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        t_abort;
        foreach (words[i]) t_write(words[i]);
        t_reset;
        t_write(words[3]);
        t_stall;
        end_sim;
    end
endmodule // dsip_serial_port_tb
bind dsip_serial_port dsip_sp_assertions #(.WORD_BITS(WORD_BITS), .CODE_BITS(CODE_BITS)) chk_u (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sync_n_i(sync_n_i), .conv_ready_i(conv_ready_i),
    .analog_output_o(analog_output_o), .pd_mode_o(pd_mode_o), .code_valid_o(code_valid_o),
    .update_pulse_o(update_pulse_o), .abort_pulse_o(abort_pulse_o), .word_ready_o(word_ready_o));
`default_nettype wire
